// *** pkg/dlp_pkg.sv ***
// package for the ddr3 low-power and termination control block
// assumes a single sys_clk domain; ddr pins arrive unsynchronised
package dlp_pkg;
  // command pin bundle, all active low
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } dlp_cmd_s;

  // mode register fields that steer termination and power-down exit
  typedef struct packed {
    logic [2:0] rtt_nom;   // mr1 a9,a6,a2
    logic [1:0] rtt_wr;    // mr2 a10,a9
    logic       pd_fast;   // mr0 a12
  } dlp_mode_s;

  // power state of the device
  typedef enum logic [2:0] {
    DLP_IDLE,
    DLP_SELF_REF,
    DLP_PD_ACT,
    DLP_PD_PRE_FAST,
    DLP_PD_PRE_SLOW,
    DLP_RESET
  } dlp_state_e;

  localparam logic [2:0] DLP_RTT_OFF     = 3'h0;
  localparam logic [1:0] DLP_RTTWR_OFF   = 2'h0;
  localparam int         DLP_CLK_MHZ     = 50;
  // minimum cke pulse in ns, rounded up to cycles of sys_clk below
  localparam int         DLP_TCKE_NS     = 60;
  localparam int         DLP_TCKE_CYC    = (DLP_TCKE_NS * DLP_CLK_MHZ + 999) / 1000;
  // dll relock delay after self-refresh exit
  localparam int         DLP_DLL_LOCK_CYC = 512;
  localparam int         DLP_CNT_W       = 10;
  localparam logic [DLP_CNT_W-1:0] DLP_CNT_ZERO = 10'h000;
  localparam logic [DLP_CNT_W-1:0] DLP_CNT_ONE  = 10'h001;
  localparam int         DLP_SYNC_STAGES = 3;
endpackage

// *** verif/dlp_ctrl_model.sv ***
// controller-side model driving cke, reset, odt and command pins
// assumes the bench sequences entry and exit calls on one sys_clk
`timescale 1ns/1ns
`default_nettype none
module dlp_ctrl_model
  import dlp_pkg::*;
(
  input  wire logic sys_clk,
  output logic      cke,
  output logic      reset_n,
  output logic      odt,
  output dlp_cmd_s  cmd
);
  localparam logic [3:0] NOP_C    = 4'h7;
  localparam logic [3:0] REF_C    = 4'h1;
  localparam int         EXIT_CYC = 8;  // exit wait in sys_clk cycles
  // pins start deselected with the device held in reset
  initial
  begin
    cke     = 1'b1;
    reset_n = 1'b0;
    odt     = 1'b0;
    cmd     = 4'hF;
  end
  // drive cke, cmd and odt just after an edge, hold them n edges
  task automatic put(input logic c, input logic [3:0] k, input logic o, input int n);
    @(posedge sys_clk);
    #2;
    cke = c;
    cmd = k;
    odt = o;
    repeat (n - 1) @(posedge sys_clk);
  endtask
  task automatic set_reset(input logic v);
    @(posedge sys_clk);
    #2;
    reset_n = v;
  endtask
  task automatic set_odt(input logic o);
    put(1'b1, NOP_C, o, 1);
  endtask
  // odt low and banks idle before refresh with cke low
  task automatic sr_enter();
    put(1'b1, NOP_C, 1'b0, 4);
    put(1'b0, REF_C, 1'b0, DLP_TCKE_CYC);
  endtask
  // residency: everything but cke and reset is don't care, so cmd and odt churn
  task automatic sr_stay(input int n);
    repeat (n) put(1'b0, 4'($urandom), 1'($urandom), 1);
  endtask
  task automatic sr_exit();
    put(1'b1, NOP_C, 1'b0, EXIT_CYC);
  endtask
  task automatic pd_enter();
    put(1'b0, NOP_C, 1'b0, DLP_TCKE_CYC);
  endtask
  task automatic pd_exit();
    put(1'b1, NOP_C, 1'b0, DLP_TCKE_CYC);
  endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench for the low-power and termination block
// assumes the controller model drives the ddr pins
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import dlp_pkg::*;
  logic       sys_clk, rst, any_bank_open, cke, reset_n, odt, slow;
  logic       self_ref, power_down, pd_active, pd_slow_exit, in_reset;
  logic       dll_enable, dll_reset, int_refresh, buf_enable;
  logic [1:0] term_dq, term_dqs, term_dm;
  dlp_cmd_s   cmd;
  dlp_mode_s  mode;
  int         n_errors, checked, i, ref_base, dll_base;
  int         n_ref = 0;
  int         n_dllrst = 0;
  dlp_ctrl_model u_ctrl (.sys_clk(sys_clk), .cke(cke), .reset_n(reset_n), .odt(odt), .cmd(cmd));
  dlp_lowpower #(.LANES(2)) u_dut (.sys_clk(sys_clk), .rst(rst), .cke(cke), .reset_n(reset_n),
    .odt(odt), .cmd(cmd), .mode(mode), .any_bank_open(any_bank_open), .self_ref(self_ref),
    .power_down(power_down), .pd_active(pd_active), .pd_slow_exit(pd_slow_exit),
    .in_reset(in_reset), .dll_enable(dll_enable), .dll_reset(dll_reset),
    .int_refresh(int_refresh), .buf_enable(buf_enable), .term_dq(term_dq),
    .term_dqs(term_dqs), .term_dm(term_dm));
  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;
  // count one-cycle pulses
  always @(posedge sys_clk)
  begin
    if (int_refresh === 1'b1) n_ref++;
    if (dll_reset === 1'b1) n_dllrst++;
  end
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [1:0] e, input logic [1:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  function automatic logic flag(input int w);
    return (w == 0) ? self_ref : (w == 1) ? power_down : in_reset;
  endfunction
  // bounded wait for a state flag
  task automatic wait_flag(input int w, input logic v);
    int k;
    for (k = 0; k < 40 && flag(w) !== v; k++) @(posedge sys_clk) #1;
    if (flag(w) !== v)
    begin
      n_errors++;
      give_verdict();
    end
  endtask
  function automatic logic [1:0] exp_term(input dlp_mode_s m, input logic o);
    return {2{o & ((m.rtt_nom != DLP_RTT_OFF) | (m.rtt_wr != DLP_RTTWR_OFF))}};
  endfunction
  task automatic idle_term(input logic o);
    u_ctrl.set_odt(o);
    repeat (6) @(posedge sys_clk);
    #1;
    chk("term_dq", exp_term(mode, o), term_dq);
    chk("term_dqs", exp_term(mode, o), term_dqs);
    chk("term_dm", exp_term(mode, o), term_dm);
  endtask
  // main sequence: reset, then alternating power-down and self-refresh
  initial
  begin
    void'($urandom(32'hE22B));
    rst = 1'b1;
    mode = 6'h00;
    any_bank_open = 1'b0;
    n_errors = 0;
    checked = 0;
    repeat (3) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    u_ctrl.set_reset(1'b1);
    wait_flag(2, 1'b0);
    chk("buf_enable", 2'h1, buf_enable);
    for (i = 0; i < 24; i++)
    begin
      @(posedge sys_clk);
      #2;
      mode = (i < 2) ? 6'(i * 63) : 6'($urandom);
      any_bank_open = i[0] ? 1'b0 : 1'($urandom);
      idle_term(1'b1);
      idle_term(1'b0);
      if (i[0])
      begin
        ref_base = n_ref;
        u_ctrl.sr_enter();
        wait_flag(0, 1'b1);
        u_ctrl.sr_stay(8);
        chk("self_ref", 2'h1, self_ref);
        chk("dll_enable", 2'h0, dll_enable);
        chk("int_refresh", 2'h1, n_ref > ref_base);
        chk("term_dq", 2'h0, term_dq);
        dll_base = n_dllrst;
        u_ctrl.sr_exit();
        wait_flag(0, 1'b0);
        repeat (2) @(posedge sys_clk);
        chk("dll_reset", 2'h1, 2'(n_dllrst - dll_base));
        chk("dll_enable", 2'h1, dll_enable);
      end
      else
      begin
        slow = ~any_bank_open & ~mode.pd_fast;
        u_ctrl.pd_enter();
        wait_flag(1, 1'b1);
        chk("pd_active", any_bank_open, pd_active);
        chk("pd_slow_exit", slow, pd_slow_exit);
        chk("dll_enable", !slow, dll_enable);
        chk("buf_enable", 2'h0, buf_enable);
        if (i == 4)
        begin
          u_ctrl.set_reset(1'b0);
          wait_flag(2, 1'b1);
          chk("power_down", 2'h0, power_down);
          u_ctrl.pd_exit();
          u_ctrl.set_reset(1'b1);
          wait_flag(2, 1'b0);
        end
        else
        begin
          u_ctrl.pd_exit();
          wait_flag(1, 1'b0);
          chk("buf_enable", 2'h1, buf_enable);
        end
      end
    end
    give_verdict();
  end
endmodule
`default_nettype wire

// *** verilog/dlp_count.sv ***
// loadable down counter, done while zero
// assumes load has priority over counting
`timescale 1ns/1ns
`default_nettype none
module dlp_count
  import dlp_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 load,
  input  wire logic [DLP_CNT_W-1:0] value,
  output logic                      done
);
  logic [DLP_CNT_W-1:0] cnt_r;
  logic [DLP_CNT_W-1:0] cnt_nxt;

  // count toward zero and hold there
  assign cnt_nxt = load ? value : ((cnt_r == DLP_CNT_ZERO) ? cnt_r : cnt_r - DLP_CNT_ONE);
  assign done    = (cnt_r == DLP_CNT_ZERO);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      cnt_r <= DLP_CNT_ZERO;
    else
      cnt_r <= cnt_nxt;
  end
endmodule
`default_nettype wire

// *** verilog/dlp_lowpower.sv ***
// ddr3 device side low-power state and termination enable logic
// assumes ddr pins are sampled on sys_clk; bank status from core logic
// Requirements of the document, tagged [Rn] where the block applies them
// R1: refresh encoding with cke low enters self-refresh
// R2: refresh is cs ras cas low, we high
// R3: dll off in self-refresh, on and reset after
// R4: controller waits 512 clocks before write
// R5: controller enters self-refresh only when precharged
// R6: controller drops odt before self-refresh entry
// R7: only cke and reset matter in self-refresh
// R8: internal refresh issued within cke pulse time
// R9: controller honours minimum self-refresh cke low
// R10: controller honours clock hold and setup
// R11: controller sends nop for exit time
// R12: controller issues zq long before dll commands
// R13: power-down enter and exit with cke and nop
// R14: controller keeps cke high during busy operations
// R15: open bank gives active, else precharge power-down
// R16: controller resets dll if unlocked at entry
// R17: buffers off in power-down except clock odt cke
// R18: a12 picks fast or slow precharge power-down
// R19: reset low in power-down enters reset state
// R20: controller holds cke at least pulse time
// R21: controller limits residency and exit latency
// R22: termination applies to all x16 lanes
// R23: odt ignored in self-refresh or disabled modes
// R24: nonzero rtt fields enable termination mode
// R25: odt low off, high on unless disabled
// R26: controller derives waits from clock period
`timescale 1ns/1ns
`default_nettype none
module dlp_lowpower
  import dlp_pkg::*;
#(
  parameter int LANES = 2
)(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             cke,
  input  wire logic             reset_n,
  input  wire logic             odt,
  input  wire dlp_cmd_s         cmd,
  input  wire dlp_mode_s        mode,
  input  wire logic             any_bank_open,
  output logic                  self_ref,
  output logic                  power_down,
  output logic                  pd_active,
  output logic                  pd_slow_exit,
  output logic                  in_reset,
  output logic                  dll_enable,
  output logic                  dll_reset,
  output logic                  int_refresh,
  output logic                  buf_enable,
  output logic [LANES-1:0]      term_dq,
  output logic [LANES-1:0]      term_dqs,
  output logic [LANES-1:0]      term_dm
);
  logic       cke_s;
  logic       rstn_s;
  logic       odt_s;
  dlp_cmd_s   cmd_s;
  dlp_state_e state_r;
  dlp_state_e state_nxt;
  logic       ref_pend_r;
  logic       dll_lock_done;
  logic       tcke_done;

  // pin synchronisers
  dlp_sync #(.W(1), .RST_VAL(1'b0)) u_sync_cke
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (cke),
    .q       (cke_s)
  );
  dlp_sync #(.W(1), .RST_VAL(1'b0)) u_sync_rstn
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (reset_n),
    .q       (rstn_s)
  );
  dlp_sync #(.W(1), .RST_VAL(1'b0)) u_sync_odt
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (odt),
    .q       (odt_s)
  );
  dlp_sync #(.W(4), .RST_VAL(4'hF)) u_sync_cmd
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (cmd),
    .q       (cmd_s)
  );

  // command decode
  wire is_refresh = ~cmd_s.cs_n & ~cmd_s.ras_n & ~cmd_s.cas_n & cmd_s.we_n; // [R2]
  wire is_nop     = cmd_s.cs_n | (cmd_s.ras_n & cmd_s.cas_n & cmd_s.we_n);
  wire sr_entry   = (state_r == DLP_IDLE) & ~cke_s & is_refresh & rstn_s; // [R1]
  wire pd_entry   = (state_r == DLP_IDLE) & ~cke_s & is_nop & rstn_s; // [R13]
  wire leave_low  = cke_s & is_nop; // [R13]
  wire in_sr      = (state_r == DLP_SELF_REF);

  // termination mode and enable
  wire term_mode  = (mode.rtt_nom != DLP_RTT_OFF) | (mode.rtt_wr != DLP_RTTWR_OFF); // [R24]
  wire term_on    = odt_s & term_mode & ~in_sr & (state_r != DLP_RESET); // [R23] [R25]

  // power state selection
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      DLP_IDLE:
        if (!rstn_s)
          state_nxt = DLP_RESET;
        else if (sr_entry)
          state_nxt = DLP_SELF_REF;
        else if (pd_entry)
          state_nxt = any_bank_open ? DLP_PD_ACT : // [R15]
                      (mode.pd_fast ? DLP_PD_PRE_FAST : DLP_PD_PRE_SLOW); // [R18]
      DLP_SELF_REF:
        if (!rstn_s)
          state_nxt = DLP_RESET;
        else if (cke_s)
          state_nxt = DLP_IDLE; // [R7]
      DLP_PD_ACT, DLP_PD_PRE_FAST, DLP_PD_PRE_SLOW:
        if (!rstn_s)
          state_nxt = DLP_RESET; // [R19]
        else if (leave_low)
          state_nxt = DLP_IDLE;
      DLP_RESET:
        if (rstn_s)
          state_nxt = DLP_IDLE;
      default:
        state_nxt = DLP_RESET;
    endcase
  end

  // next values of the registered status outputs
  wire self_ref_nxt     = (state_nxt == DLP_SELF_REF);
  wire pd_active_nxt    = (state_nxt == DLP_PD_ACT); // [R15]
  wire pd_slow_exit_nxt = (state_nxt == DLP_PD_PRE_SLOW); // [R18]
  wire power_down_nxt   = pd_active_nxt | (state_nxt == DLP_PD_PRE_FAST) | pd_slow_exit_nxt;
  wire in_reset_nxt     = (state_nxt == DLP_RESET); // [R19]
  wire buf_enable_nxt   = (state_nxt == DLP_IDLE); // [R17]
  wire dll_reset_nxt    = in_sr & buf_enable_nxt; // [R3]
  wire dll_enable_nxt   = ~self_ref_nxt & ~pd_slow_exit_nxt & ~in_reset_nxt; // [R3] [R18]

  // dll relock timer after self-refresh
  dlp_count u_dll_cnt
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .load    (dll_reset_nxt),
    .value   (DLP_CNT_W'(DLP_DLL_LOCK_CYC)),
    .done    (dll_lock_done)
  );

  // internal refresh deadline on self-refresh entry
  dlp_count u_tcke_cnt
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .load    (sr_entry),
    .value   (DLP_CNT_W'(DLP_TCKE_CYC - 1)),
    .done    (tcke_done)
  );

  // state and status registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r      <= DLP_RESET;
      ref_pend_r   <= 1'b0;
      self_ref     <= 1'b0;
      power_down   <= 1'b0;
      pd_active    <= 1'b0;
      pd_slow_exit <= 1'b0;
      in_reset     <= 1'b1;
      dll_enable   <= 1'b0;
      dll_reset    <= 1'b0;
      int_refresh  <= 1'b0;
      buf_enable   <= 1'b0;
      term_dq      <= '0;
      term_dqs     <= '0;
      term_dm      <= '0;
    end
    else
    begin
      state_r      <= state_nxt;
      ref_pend_r   <= sr_entry;
      self_ref     <= self_ref_nxt;
      power_down   <= power_down_nxt;
      pd_active    <= pd_active_nxt; // [R15]
      pd_slow_exit <= pd_slow_exit_nxt; // [R18]
      in_reset     <= in_reset_nxt;
      dll_enable   <= dll_enable_nxt; // [R3] [R18]
      dll_reset    <= dll_reset_nxt; // [R3]
      int_refresh  <= ref_pend_r; // [R8]
      buf_enable   <= buf_enable_nxt; // [R17]
      term_dq      <= {LANES{term_on}}; // [R22]
      term_dqs     <= {LANES{term_on}}; // [R22]
      term_dm      <= {LANES{term_on}}; // [R22]
    end
  end

  // relock and refresh deadline counters, checked here
  AST_REF_IN_TCKE: assert property (@(posedge sys_clk) disable iff (rst) // [R8]
    int_refresh |-> !tcke_done)
    else $error("internal refresh after cke pulse time");
  AST_DLL_RELOCK: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
    dll_reset |-> !dll_lock_done)
    else $error("dll relock timer not started");

  // self-refresh exit, residency and no entry while cke is high
  AST_SR_EXIT: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    in_sr && cke_s && rstn_s |=> !self_ref && dll_enable && dll_reset)
    else $error("self-refresh not left on cke high");
  AST_NO_SR_CKE_HIGH: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
    state_r == DLP_IDLE && cke_s && rstn_s |=> !self_ref && !power_down)
    else $error("low-power state entered with cke high");
  AST_SR_NO_TERM: assert property (@(posedge sys_clk) disable iff (rst) // [R23]
    self_ref |=> term_dq == '0)
    else $error("termination on in self-refresh");
  AST_SR_BUF_OFF: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    self_ref |-> !buf_enable)
    else $error("inputs live in self-refresh");
  AST_INT_REF_ONCE: assert property (@(posedge sys_clk) disable iff (rst) // [R8]
    int_refresh |=> !int_refresh)
    else $error("internal refresh pulse too long");

  AST_SR_ENTRY: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
    sr_entry |=> self_ref)
    else $error("self-refresh not entered");
  AST_SR_DLL_OFF: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
    self_ref |-> !dll_enable)
    else $error("dll on in self-refresh");
  AST_SR_DLL_RESET: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
    $fell(self_ref) && !in_reset |-> dll_reset && dll_enable)
    else $error("dll not reset on exit");
  AST_INT_REF: assert property (@(posedge sys_clk) disable iff (rst) // [R8]
    sr_entry |-> ##2 int_refresh)
    else $error("internal refresh missing");
  AST_SR_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    in_sr && !cke_s && rstn_s |=> self_ref)
    else $error("self-refresh left without cke");
  AST_PD_KIND: assert property (@(posedge sys_clk) disable iff (rst) // [R15]
    pd_entry && rstn_s |=> pd_active == $past(any_bank_open))
    else $error("wrong power-down kind");
  AST_PD_SLOW: assert property (@(posedge sys_clk) disable iff (rst) // [R18]
    pd_entry && rstn_s && !any_bank_open && !mode.pd_fast |=> pd_slow_exit && !dll_enable)
    else $error("slow exit not chosen");
  AST_PD_RESET: assert property (@(posedge sys_clk) disable iff (rst) // [R19]
    power_down && !rstn_s |=> in_reset && !power_down)
    else $error("reset ignored in power-down");
  AST_BUF_OFF: assert property (@(posedge sys_clk) disable iff (rst) // [R17]
    power_down |-> !buf_enable)
    else $error("buffers on in power-down");
  AST_TERM: assert property (@(posedge sys_clk) disable iff (rst) // [R25]
    odt_s && term_mode && state_r == DLP_IDLE |=> term_dq == {LANES{1'b1}})
    else $error("termination not on");
  AST_TERM_OFF: assert property (@(posedge sys_clk) disable iff (rst) // [R23]
    in_sr || !term_mode |=> term_dqs == '0 && term_dm == '0)
    else $error("termination on while ignored");

  // power-down entry, hold and exit
  AST_PD_ENTRY: assert property (@(posedge sys_clk) disable iff (rst) // [R13]
    pd_entry |=> power_down && !buf_enable)
    else $error("power-down not entered");
  AST_PD_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // [R13]
    power_down && !cke_s && rstn_s |=> power_down)
    else $error("power-down left with cke low");
  AST_PD_EXIT: assert property (@(posedge sys_clk) disable iff (rst) // [R13]
    power_down && leave_low && rstn_s |=> !power_down && buf_enable)
    else $error("power-down not left");
  AST_PD_FAST: assert property (@(posedge sys_clk) disable iff (rst) // [R18]
    pd_entry && !any_bank_open && mode.pd_fast |=> !pd_slow_exit && dll_enable && !pd_active)
    else $error("fast exit not chosen");
  AST_PD_ACT_DLL: assert property (@(posedge sys_clk) disable iff (rst) // [R18]
    pd_active |-> dll_enable && power_down)
    else $error("dll off in active power-down");
  AST_PD_KIND_EXCL: assert property (@(posedge sys_clk) disable iff (rst) // [R15]
    pd_active |-> !pd_slow_exit)
    else $error("two power-down kinds at once");
  AST_IDLE_BUF: assert property (@(posedge sys_clk) disable iff (rst) // [R13]
    state_r == DLP_IDLE && cke_s && rstn_s |=> buf_enable)
    else $error("buffers off in idle");

  // reset pin and termination truth table
  AST_ANY_RESET: assert property (@(posedge sys_clk) disable iff (rst) // [R19]
    !rstn_s |=> in_reset && !power_down && !self_ref)
    else $error("reset pin ignored");
  AST_TERM_ODT_LOW: assert property (@(posedge sys_clk) disable iff (rst) // [R25]
    !odt_s |=> term_dq == '0 && term_dqs == '0)
    else $error("termination on with odt low");
  AST_TERM_LANES: assert property (@(posedge sys_clk) disable iff (rst) // [R22]
    term_dq == term_dqs && term_dqs == term_dm)
    else $error("lanes terminated unequally");
endmodule
`default_nettype wire

// *** verilog/dlp_sync.sv ***
// three-flop input synchroniser with agreement filter
// assumes a single destination clock sys_clk
`timescale 1ns/1ns
`default_nettype none
module dlp_sync
  import dlp_pkg::*;
#(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
)(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_nxt;

  // output follows only when stage two and three agree
  assign q_nxt = (s2_r == s3_r) ? s3_r : q;

  // capture chain
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      q    <= RST_VAL;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q    <= q_nxt;
    end
  end
endmodule
`default_nettype wire
